// ### pkg/cfp_pkg.sv
// cfp_pkg: constants and types for the configuration fuse protection block
// assumes byte-wide table access at 22-bit addresses into the configuration space
//
// Overview of operation
// RQ1: two-bit brown-out level code picks 2.0, 2.7, 4.2 or 4.5 volt threshold.
// RQ2: brown-out reset on when its enable bit is 1, off when 0.
// RQ3: power-up delay enable is active low; 0 enables the delay.
// RQ4: watchdog divider ratio is two raised to the three-bit code.
// RQ5: watchdog hardware bit 1 forces watchdog on; 0 defers to software bit.
// RQ6: debugger bit 0 enables debugger and claims port B pins 6 and 7.
// RQ7: low-voltage programming enabled when its bit is 1.
// RQ8: stack fault resets device only when its bit is 1.
// RQ9: four code guard bits protect four program blocks when 0.
// RQ10: data EEPROM code protected when its guard bit is 0.
// RQ11: boot block code protected when its guard bit is 0.
// RQ12: code guard bits reset to 1 and can only be cleared.
// RQ13: four write guard bits block writes to their program blocks when 0.
// RQ14: data EEPROM writes blocked when its write guard bit is 0.
// RQ15: boot block writes blocked when its write guard bit is 0.
// RQ16: config write guard 0 blocks config writes; bit read-only in user mode.
// RQ17: read guard 0 denies table reads of a block from other blocks.
// RQ18: boot read guard 0 denies boot table reads from outside boot block.
// RQ19: on the small variant, programmer keeps block 2 and 3 guards at 1.
// RQ20: unimplemented configuration bits always read as 0.
// RQ21: implemented configuration bits read 1 while unprogrammed.
// RQ22: configuration bytes reachable only by table reads and writes.
// RQ23: decoder checks address and issuing block, then grants or denies.
`default_nettype none
package cfp_pkg;
   // ------------------------------------------------------------
   // address map
   // ------------------------------------------------------------
   localparam logic [21:0] CFP_ADDR_BOR = 22'h300002;
   localparam logic [21:0] CFP_ADDR_WDG = 22'h300003;
   localparam logic [21:0] CFP_ADDR_DBG = 22'h300006;
   localparam logic [21:0] CFP_ADDR_CPL = 22'h300008;
   localparam logic [21:0] CFP_ADDR_CPH = 22'h300009;
   localparam logic [21:0] CFP_ADDR_WPL = 22'h30000A;
   localparam logic [21:0] CFP_ADDR_WPH = 22'h30000B;
   localparam logic [21:0] CFP_ADDR_RPL = 22'h30000C;
   localparam logic [21:0] CFP_ADDR_RPH = 22'h30000D;
   localparam logic [21:0] CFP_CFG_LO = 22'h300000;
   localparam logic [21:0] CFP_CFG_HI = 22'h3000FF;
   localparam logic [21:0] CFP_BOOT_END = 22'h0001FF;
   localparam logic [21:0] CFP_PROG_END = 22'h007FFF;
   // data eeprom is told apart by the is_eeprom flag; this is only a probe address
   localparam logic [21:0] CFP_EE_LO = 22'h200000;
   localparam int CFP_BLK_LSB = 13;
   // ------------------------------------------------------------
   // implemented bit masks, unprogrammed values equal the masks
   // ------------------------------------------------------------
   localparam logic [7:0] CFP_MASK_BOR = 8'h0F;
   localparam logic [7:0] CFP_MASK_WDG = 8'h0F;
   localparam logic [7:0] CFP_MASK_DBG = 8'h85;
   localparam logic [7:0] CFP_MASK_CPL = 8'h0F;
   localparam logic [7:0] CFP_MASK_CPH = 8'hC0;
   localparam logic [7:0] CFP_MASK_WPL = 8'h0F;
   localparam logic [7:0] CFP_MASK_WPH = 8'hE0;
   localparam logic [7:0] CFP_MASK_RPL = 8'h0F;
   localparam logic [7:0] CFP_MASK_RPH = 8'h40;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CFP_POS_PDLY = 0;
   localparam int CFP_POS_BRST = 1;
   localparam int CFP_POS_BLVL = 2;
   localparam int CFP_POS_WDEN = 0;
   localparam int CFP_POS_WDPS = 1;
   localparam int CFP_POS_STK = 0;
   localparam int CFP_POS_LOWV = 2;
   localparam int CFP_POS_DBG = 7;
   localparam int CFP_POS_EE = 7;
   localparam int CFP_POS_BOOT = 6;
   localparam int CFP_POS_CFGW = 5;

   typedef enum logic [1:0] {
      CFP_BOR_4V5 = 2'b00,
      CFP_BOR_4V2 = 2'b01,
      CFP_BOR_2V7 = 2'b10,
      CFP_BOR_2V0 = 2'b11
   } cfp_bor_level_t;

   // decoded settings handed to reset, watchdog and port logic
   typedef struct packed {
      cfp_bor_level_t brownout_threshold;
      logic brownout_reset_on;
      logic powerup_delay_timer_on;
      logic [7:0] watchdog_divide_ratio;
      logic watchdog_run;
      logic debugger_on;
      logic lowvolt_programming_on;
      logic stack_fault_reset_on;
   } cfp_settings_t;

   // one memory access presented to the protection decoder
   typedef struct packed {
      logic valid;
      logic is_write;
      logic is_table_read;
      logic is_eeprom;
      logic [21:0] addr;
      logic [21:0] issuer_pc;
   } cfp_access_t;
endpackage : cfp_pkg
`default_nettype wire

// ### src/cfp_config_fuse.sv
// cfp_config_fuse: configuration byte bank, table access port and protection decoder
// assumes table access requests arrive synchronous to clk_sys_in from the memory unit
`timescale 1ns/1ps
`default_nettype none
module cfp_config_fuse (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic user_mode_in,
   input wire logic watchdog_sw_on_in,
   input wire logic tbl_wr_in,
   input wire logic tbl_rd_in,
   input wire logic [21:0] tbl_addr_in,
   input wire logic [7:0] tbl_wdata_in,
   output logic [7:0] tbl_rdata_out,
   output logic tbl_wr_done_out,
   output logic tbl_wr_denied_out,
   input wire cfp_pkg::cfp_access_t acc_in,
   output logic acc_grant_out,
   output logic acc_deny_out,
   output cfp_pkg::cfp_settings_t settings_out,
   output logic portb_pin6_debug_out,
   output logic portb_pin7_debug_out
);
   import cfp_pkg::*;

   // ------------------------------------------------------------
   // reset release synchroniser
   // ------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire logic rstn = rst_sync_ff;

   // ------------------------------------------------------------
   // configuration bytes
   // ------------------------------------------------------------
   // reset models the unprogrammed array; real cells would hold across resets
   logic [7:0] brownout_powerup_config_ff;
   logic [7:0] watchdog_config_ff;
   logic [7:0] debug_program_stack_config_ff;
   logic [7:0] block_code_protect_ff;
   logic [7:0] eeprom_boot_code_protect_ff;
   logic [7:0] block_write_protect_ff;
   logic [7:0] eeprom_boot_cfg_write_protect_ff;
   logic [7:0] block_tableread_protect_ff;
   logic [7:0] boot_tableread_protect_ff;

   logic cfg_wr_ok;
   // RQ16 config write guard
   assign cfg_wr_ok = eeprom_boot_cfg_write_protect_ff[CFP_POS_CFGW];

   // RQ21 unprogrammed ones
   always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
         brownout_powerup_config_ff <= CFP_MASK_BOR;
         watchdog_config_ff <= CFP_MASK_WDG;
         debug_program_stack_config_ff <= CFP_MASK_DBG;
         block_write_protect_ff <= CFP_MASK_WPL;
         eeprom_boot_cfg_write_protect_ff <= CFP_MASK_WPH;
         block_tableread_protect_ff <= CFP_MASK_RPL;
         boot_tableread_protect_ff <= CFP_MASK_RPH;
      end else if (tbl_wr_in && cfg_wr_ok) begin
         // RQ20 unimplemented bits masked
         case (tbl_addr_in)
            CFP_ADDR_BOR: begin
               brownout_powerup_config_ff <= tbl_wdata_in & CFP_MASK_BOR;
            end
            CFP_ADDR_WDG: begin
               watchdog_config_ff <= tbl_wdata_in & CFP_MASK_WDG;
            end
            CFP_ADDR_DBG: begin
               debug_program_stack_config_ff <= tbl_wdata_in & CFP_MASK_DBG;
            end
            CFP_ADDR_WPL: begin
               block_write_protect_ff <= tbl_wdata_in & CFP_MASK_WPL;
            end
            CFP_ADDR_WPH: begin
               // RQ16 read-only in user mode
               if (user_mode_in) begin
                  eeprom_boot_cfg_write_protect_ff <= (tbl_wdata_in & 8'hC0) |
                     (eeprom_boot_cfg_write_protect_ff & 8'h20);
               end else begin
                  eeprom_boot_cfg_write_protect_ff <= tbl_wdata_in & CFP_MASK_WPH;
               end
            end
            CFP_ADDR_RPL: begin
               block_tableread_protect_ff <= tbl_wdata_in & CFP_MASK_RPL;
            end
            CFP_ADDR_RPH: begin
               boot_tableread_protect_ff <= tbl_wdata_in & CFP_MASK_RPH;
            end
            default: begin
            end
         endcase
      end
   end

   // RQ12 clear-only code guards
   always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
         block_code_protect_ff <= CFP_MASK_CPL;
         eeprom_boot_code_protect_ff <= CFP_MASK_CPH;
      end else if (tbl_wr_in && cfg_wr_ok) begin
         if (tbl_addr_in == CFP_ADDR_CPL) begin
            block_code_protect_ff <= block_code_protect_ff & tbl_wdata_in;
         end
         if (tbl_addr_in == CFP_ADDR_CPH) begin
            eeprom_boot_code_protect_ff <= eeprom_boot_code_protect_ff & tbl_wdata_in;
         end
      end
   end

   // ------------------------------------------------------------
   // table access answer
   // ------------------------------------------------------------
   logic in_cfg;
   assign in_cfg = (tbl_addr_in >= CFP_CFG_LO) && (tbl_addr_in <= CFP_CFG_HI);

   // RQ22 table path only
   always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
         tbl_rdata_out <= 8'h00;
      end else if (tbl_rd_in) begin
         case (tbl_addr_in)
            CFP_ADDR_BOR: tbl_rdata_out <= brownout_powerup_config_ff;
            CFP_ADDR_WDG: tbl_rdata_out <= watchdog_config_ff;
            CFP_ADDR_DBG: tbl_rdata_out <= debug_program_stack_config_ff;
            CFP_ADDR_CPL: tbl_rdata_out <= block_code_protect_ff;
            CFP_ADDR_CPH: tbl_rdata_out <= eeprom_boot_code_protect_ff;
            CFP_ADDR_WPL: tbl_rdata_out <= block_write_protect_ff;
            CFP_ADDR_WPH: tbl_rdata_out <= eeprom_boot_cfg_write_protect_ff;
            CFP_ADDR_RPL: tbl_rdata_out <= block_tableread_protect_ff;
            CFP_ADDR_RPH: tbl_rdata_out <= boot_tableread_protect_ff;
            default: tbl_rdata_out <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
         tbl_wr_done_out <= 1'b0;
         tbl_wr_denied_out <= 1'b0;
      end else begin
         tbl_wr_done_out <= tbl_wr_in && in_cfg && cfg_wr_ok;
         tbl_wr_denied_out <= tbl_wr_in && in_cfg && !cfg_wr_ok;
      end
   end

   // ------------------------------------------------------------
   // decoded settings
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
         settings_out <= '0;
         portb_pin6_debug_out <= 1'b0;
         portb_pin7_debug_out <= 1'b0;
      end else begin
         // RQ1 threshold code
         settings_out.brownout_threshold <= cfp_bor_level_t'(brownout_powerup_config_ff[CFP_POS_BLVL +: 2]);
         // RQ2 brown-out enable
         settings_out.brownout_reset_on <= brownout_powerup_config_ff[CFP_POS_BRST];
         // RQ3 active-low delay
         settings_out.powerup_delay_timer_on <= !brownout_powerup_config_ff[CFP_POS_PDLY];
         // RQ4 power of two
         settings_out.watchdog_divide_ratio <= 8'h01 << watchdog_config_ff[CFP_POS_WDPS +: 3];
         // RQ5 hardware or software
         settings_out.watchdog_run <= watchdog_config_ff[CFP_POS_WDEN] | watchdog_sw_on_in;
         // RQ6 debugger owns pins
         settings_out.debugger_on <= !debug_program_stack_config_ff[CFP_POS_DBG];
         portb_pin6_debug_out <= !debug_program_stack_config_ff[CFP_POS_DBG];
         portb_pin7_debug_out <= !debug_program_stack_config_ff[CFP_POS_DBG];
         // RQ7 low-voltage programming
         settings_out.lowvolt_programming_on <= debug_program_stack_config_ff[CFP_POS_LOWV];
         // RQ8 stack fault reset
         settings_out.stack_fault_reset_on <= debug_program_stack_config_ff[CFP_POS_STK];
      end
   end

   // ------------------------------------------------------------
   // protection decoder
   // ------------------------------------------------------------
   // block index 0..3 from address bits 14:13; boot lies inside block 0's span
   logic acc_boot;
   logic acc_prog;
   logic acc_cfg;
   logic pc_boot;
   logic [1:0] acc_blk;
   logic [1:0] pc_blk;
   logic same_region;
   logic deny;
   assign acc_boot = acc_in.addr <= CFP_BOOT_END;
   assign acc_prog = acc_in.addr <= CFP_PROG_END;
   assign acc_cfg = (acc_in.addr >= CFP_CFG_LO) && (acc_in.addr <= CFP_CFG_HI);
   assign pc_boot = acc_in.issuer_pc <= CFP_BOOT_END;
   assign acc_blk = acc_in.addr[CFP_BLK_LSB +: 2];
   assign pc_blk = acc_in.issuer_pc[CFP_BLK_LSB +: 2];
   assign same_region = acc_boot ? pc_boot :
      (!pc_boot && (acc_in.issuer_pc <= CFP_PROG_END) && (pc_blk == acc_blk));

   // RQ23 grant or deny
   always_comb begin
      deny = 1'b0;
      if (acc_in.is_eeprom) begin
         // RQ14 eeprom write guard
         if (acc_in.is_write && !eeprom_boot_cfg_write_protect_ff[CFP_POS_EE]) deny = 1'b1;
         // RQ10 eeprom code guard
         if (!acc_in.is_write && !eeprom_boot_code_protect_ff[CFP_POS_EE]) deny = 1'b1;
      end else if (acc_cfg) begin
         if (acc_in.is_write && !cfg_wr_ok) deny = 1'b1;
      end else if (acc_boot) begin
         // RQ15 boot write guard
         if (acc_in.is_write && !eeprom_boot_cfg_write_protect_ff[CFP_POS_BOOT]) deny = 1'b1;
         // RQ11 RQ18 boot code and read guards
         if (acc_in.is_table_read && !same_region &&
             (!boot_tableread_protect_ff[CFP_POS_BOOT] || !eeprom_boot_code_protect_ff[CFP_POS_BOOT])) deny = 1'b1;
      end else if (acc_prog) begin
         // RQ13 block write guard
         if (acc_in.is_write && !block_write_protect_ff[acc_blk]) deny = 1'b1;
         // RQ9 RQ17 block code and read guards
         if (acc_in.is_table_read && !same_region &&
             (!block_tableread_protect_ff[acc_blk] || !block_code_protect_ff[acc_blk])) deny = 1'b1;
      end
   end
   assign acc_grant_out = acc_in.valid && !deny;
   assign acc_deny_out = acc_in.valid && deny;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_cp_clear_only;
      @(posedge clk_sys_in) disable iff (!rstn)
      1'b1 |=> ((block_code_protect_ff & ~$past(block_code_protect_ff)) == 8'h00);
   endproperty
   a_cp_clear_only: assert property (p_cp_clear_only) else $error("code guard bit went 0 to 1"); // RQ12

   property p_unimpl_zero;
      @(posedge clk_sys_in) disable iff (!rstn)
      tbl_rd_in |=> ((tbl_rdata_out & ~CFP_MASK_BOR) == 8'h00) || ($past(tbl_addr_in) != CFP_ADDR_BOR);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read nonzero"); // RQ20

   // settings lag the byte by one edge, so compare against the byte one edge back
   property p_pdly_low;
      @(posedge clk_sys_in) disable iff (!rstn)
      $stable(brownout_powerup_config_ff) |=>
         settings_out.powerup_delay_timer_on == !$past(brownout_powerup_config_ff[CFP_POS_PDLY]);
   endproperty
   a_pdly_low: assert property (p_pdly_low) else $error("power-up delay polarity wrong"); // RQ3

   property p_bor_en;
      @(posedge clk_sys_in) disable iff (!rstn)
      $stable(brownout_powerup_config_ff) |=>
         settings_out.brownout_reset_on == $past(brownout_powerup_config_ff[CFP_POS_BRST]);
   endproperty
   a_bor_en: assert property (p_bor_en) else $error("brown-out enable wrong"); // RQ2

   property p_wdg_hw;
      @(posedge clk_sys_in) disable iff (!rstn)
      watchdog_config_ff[0] |=> settings_out.watchdog_run;
   endproperty
   a_wdg_hw: assert property (p_wdg_hw) else $error("watchdog off despite hardware enable"); // RQ5

   property p_dbg_pins;
      @(posedge clk_sys_in) disable iff (!rstn)
      !debug_program_stack_config_ff[7] ##1 !debug_program_stack_config_ff[7] |-> portb_pin6_debug_out && portb_pin7_debug_out;
   endproperty
   a_dbg_pins: assert property (p_dbg_pins) else $error("debug pins not claimed"); // RQ6

   property p_cfg_wr_block;
      @(posedge clk_sys_in) disable iff (!rstn)
      tbl_wr_in && in_cfg && !cfg_wr_ok |=> tbl_wr_denied_out && $stable(watchdog_config_ff);
   endproperty
   a_cfg_wr_block: assert property (p_cfg_wr_block) else $error("config write not blocked"); // RQ16

   property p_blk_write;
      @(posedge clk_sys_in) disable iff (!rstn)
      acc_in.valid && acc_in.is_write && !acc_in.is_eeprom && !acc_boot && acc_prog &&
      !block_write_protect_ff[acc_blk] |-> acc_deny_out && !acc_grant_out;
   endproperty
   a_blk_write: assert property (p_blk_write) else $error("protected block write granted"); // RQ13
endmodule // cfp_config_fuse
`default_nettype wire

// ### dv/cfp_prog_model.sv
// cfp_prog_model: programmer and memory-access partner driving table bus and access port
// assumes one rising-edge clock; each request is launched 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module cfp_prog_model #(
   parameter bit SMALL_PART = 1'b0
) (
   input wire logic clk_in,
   output var logic tbl_wr_out,
   output var logic tbl_rd_out,
   output var logic [21:0] tbl_addr_out,
   output var logic [7:0] tbl_wdata_out,
   input wire logic [7:0] tbl_rdata_in,
   input wire logic tbl_wr_done_in,
   input wire logic tbl_wr_denied_in,
   output var cfp_pkg::cfp_access_t acc_out,
   input wire logic acc_grant_in,
   input wire logic acc_deny_in
);
   import cfp_pkg::*;

   initial begin
      tbl_wr_out = 1'b0;
      tbl_rd_out = 1'b0;
      tbl_addr_out = 22'h155555;
      tbl_wdata_out = 8'hA5;
      acc_out = '0;
   end

   task automatic tbl_write(input logic [21:0] addr, input logic [7:0] data, output logic done,
                            output logic denied);
      logic [7:0] d;
      d = data;
      if (SMALL_PART && (addr == CFP_ADDR_CPL || addr == CFP_ADDR_WPL || addr == CFP_ADDR_RPL)) begin
         d = d | 8'h0C;
      end
      @(posedge clk_in);
      #1;
      tbl_wr_out = 1'b1;
      tbl_addr_out = addr;
      tbl_wdata_out = d;
      @(posedge clk_in);
      #1;
      tbl_wr_out = 1'b0;
      tbl_addr_out = ~addr;
      tbl_wdata_out = ~d;
      done = tbl_wr_done_in;
      denied = tbl_wr_denied_in;
   endtask

   task automatic tbl_read(input logic [21:0] addr, output logic [7:0] data);
      @(posedge clk_in);
      #1;
      tbl_rd_out = 1'b1;
      tbl_addr_out = addr;
      @(posedge clk_in);
      #1;
      tbl_rd_out = 1'b0;
      tbl_addr_out = ~addr;
      data = tbl_rdata_in;
   endtask

   // grant and deny are combinational, so sample well inside the cycle
   task automatic probe(input logic [21:0] addr, input logic [21:0] pc, input logic wr, input logic tr,
                        input logic ee, output logic grant, output logic deny);
      @(posedge clk_in);
      #1;
      acc_out = '{valid: 1'b1, is_write: wr, is_table_read: tr, is_eeprom: ee, addr: addr, issuer_pc: pc};
      #20;
      grant = acc_grant_in;
      deny = acc_deny_in;
      @(posedge clk_in);
      #1;
      acc_out.valid = 1'b0;
      acc_out.addr = ~addr;
   endtask
endmodule // cfp_prog_model
`default_nettype wire

// ### dv/config_fuse_protection_tb.sv
// config_fuse_protection_tb: self-checking bench for the configuration fuse block
// assumes cfp_pkg compiled first and cfp_prog_model as the partner
`timescale 1ns/1ps
`default_nettype none
module config_fuse_protection_tb;
   import cfp_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic user_mode = 1'b0;
   logic wd_sw = 1'b0;
   logic tbl_wr, tbl_rd, wr_done, wr_denied, grant, deny, pin6, pin7;
   logic [21:0] tbl_addr;
   logic [7:0] tbl_wdata, tbl_rdata;
   cfp_access_t acc;
   cfp_settings_t st;
   int num_errors = 0;
   int cmp_count = 0;

   always #50 clk_sys_in = ~clk_sys_in;

   cfp_config_fuse i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .user_mode_in(user_mode),
      .watchdog_sw_on_in(wd_sw), .tbl_wr_in(tbl_wr), .tbl_rd_in(tbl_rd), .tbl_addr_in(tbl_addr),
      .tbl_wdata_in(tbl_wdata), .tbl_rdata_out(tbl_rdata), .tbl_wr_done_out(wr_done),
      .tbl_wr_denied_out(wr_denied), .acc_in(acc), .acc_grant_out(grant), .acc_deny_out(deny),
      .settings_out(st), .portb_pin6_debug_out(pin6), .portb_pin7_debug_out(pin7));

   cfp_prog_model i_prog (.clk_in(clk_sys_in), .tbl_wr_out(tbl_wr), .tbl_rd_out(tbl_rd),
      .tbl_addr_out(tbl_addr), .tbl_wdata_out(tbl_wdata), .tbl_rdata_in(tbl_rdata),
      .tbl_wr_done_in(wr_done), .tbl_wr_denied_in(wr_denied), .acc_out(acc),
      .acc_grant_in(grant), .acc_deny_in(deny));

   // ----------------------------------------
   // compare and access helpers
   // ----------------------------------------
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // extra edge at the end lets settings_out catch up with the byte
   task automatic wr(input logic [21:0] a, input logic [7:0] d, input logic ok);
      logic dn, dd;
      i_prog.tbl_write(a, d, dn, dd);
      chk_bit("write done", ok, dn);
      chk_bit("write denied", ~ok, dd);
      @(posedge clk_sys_in);
      #1;
   endtask

   task automatic rd(input logic [21:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_prog.tbl_read(a, d);
      chk_byte("read byte", exp, d);
   endtask

   task automatic pr(input logic [21:0] a, input logic [21:0] pc, input logic [2:0] kind, input logic ok);
      logic g, n;
      i_prog.probe(a, pc, kind[2], kind[1], kind[0], g, n);
      chk_bit("grant", ok, g);
      chk_bit("deny", ~ok, n);
   endtask

   task automatic do_reset(input int n);
      rstn_in = 1'b0;
      repeat (n) @(posedge clk_sys_in);
      #1;
      rstn_in = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
   endtask

   localparam logic [2:0] K_WR = 3'b100;
   localparam logic [2:0] K_TR = 3'b010;
   localparam logic [2:0] K_EW = 3'b101;
   localparam logic [2:0] K_ER = 3'b011;
   localparam logic [21:0] ADDRS [9] = '{CFP_ADDR_BOR, CFP_ADDR_WDG, CFP_ADDR_DBG, CFP_ADDR_CPL,
      CFP_ADDR_CPH, CFP_ADDR_WPL, CFP_ADDR_WPH, CFP_ADDR_RPL, CFP_ADDR_RPH};
   localparam logic [7:0] MASKS [9] = '{8'h0F, 8'h0F, 8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      num_errors++;
      finish_test();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      do_reset(10);
      for (int i = 0; i < 9; i++) begin
         rd(ADDRS[i], MASKS[i]);
      end
      rd(22'h300004, 8'h00);
      chk_byte("unprog settings", 8'hFF, {st.brownout_threshold, st.brownout_reset_on, ~st.powerup_delay_timer_on,
         st.watchdog_run, ~st.debugger_on, st.lowvolt_programming_on, st.stack_fault_reset_on});
      chk_byte("unprog ratio", 8'h80, st.watchdog_divide_ratio);
      for (int c = 0; c < 16; c++) begin
         wr(CFP_ADDR_BOR, 8'(c) | 8'hF0, 1'b1);
         rd(CFP_ADDR_BOR, 8'(c));
         chk_byte("bor level", {6'h00, 2'(c >> 2)}, {6'h00, st.brownout_threshold});
         chk_bit("bor on", c[1], st.brownout_reset_on);
         chk_bit("delay on", ~c[0], st.powerup_delay_timer_on);
      end
      for (int c = 0; c < 32; c++) begin
         wd_sw = c[4];
         wr(CFP_ADDR_WDG, 8'(c & 15), 1'b1);
         chk_byte("wdg ratio", 8'h01 << ((c >> 1) & 7), st.watchdog_divide_ratio);
         chk_bit("wdg run", c[0] | c[4], st.watchdog_run);
      end
      for (int c = 0; c < 2; c++) begin
         wr(CFP_ADDR_DBG, c[0] ? 8'hFF : 8'h00, 1'b1);
         rd(CFP_ADDR_DBG, c[0] ? 8'h85 : 8'h00);
         chk_bit("debugger on", ~c[0], st.debugger_on);
         chk_bit("pin6 owned", ~c[0], pin6);
         chk_bit("pin7 owned", ~c[0], pin7);
         chk_bit("lowvolt on", c[0], st.lowvolt_programming_on);
         chk_bit("stack reset", c[0], st.stack_fault_reset_on);
      end
      pr(22'h004010, 22'h000300, K_TR, 1'b1);
      wr(CFP_ADDR_CPL, 8'h0D, 1'b1);
      wr(CFP_ADDR_CPL, 8'h0F, 1'b1);
      rd(CFP_ADDR_CPL, 8'h0D);
      pr(22'h002100, 22'h000400, K_TR, 1'b0);
      pr(22'h002100, 22'h002400, K_TR, 1'b1);
      wr(CFP_ADDR_CPH, 8'h80, 1'b1);
      pr(22'h000010, 22'h000400, K_TR, 1'b0);
      pr(CFP_EE_LO, 22'h000400, K_ER, 1'b1);
      wr(CFP_ADDR_CPH, 8'hC0, 1'b1);
      rd(CFP_ADDR_CPH, 8'h80);
      wr(CFP_ADDR_CPH, 8'h00, 1'b1);
      pr(CFP_EE_LO, 22'h000400, K_ER, 1'b0);
      do_reset(2);
      rd(CFP_ADDR_CPH, 8'hC0);
      wr(CFP_ADDR_WPL, 8'h0E, 1'b1);
      pr(22'h000300, 22'h002000, K_WR, 1'b0);
      pr(22'h002000, 22'h000300, K_WR, 1'b1);
      wr(CFP_ADDR_WPH, 8'hA0, 1'b1);
      pr(22'h000100, 22'h002000, K_WR, 1'b0);
      pr(CFP_EE_LO, 22'h002000, K_EW, 1'b1);
      wr(CFP_ADDR_WPH, 8'h60, 1'b1);
      pr(CFP_EE_LO, 22'h002000, K_EW, 1'b0);
      wr(CFP_ADDR_RPL, 8'h0B, 1'b1);
      pr(22'h004010, 22'h000600, K_TR, 1'b0);
      pr(22'h004010, 22'h004800, K_TR, 1'b1);
      wr(CFP_ADDR_RPH, 8'h00, 1'b1);
      pr(22'h000010, 22'h000300, K_TR, 1'b0);
      pr(22'h000010, 22'h000100, K_TR, 1'b1);
      user_mode = 1'b1;
      wr(CFP_ADDR_WPH, 8'h40, 1'b1);
      rd(CFP_ADDR_WPH, 8'h60);
      user_mode = 1'b0;
      wr(CFP_ADDR_WPH, 8'h40, 1'b1);
      rd(CFP_ADDR_WPH, 8'h40);
      wr(CFP_ADDR_BOR, 8'h00, 1'b0);
      rd(CFP_ADDR_BOR, 8'h0F);
      pr(22'h300002, 22'h000300, K_WR, 1'b0);
      do_reset(1);
      rd(CFP_ADDR_WPH, 8'hE0);
      finish_test();
   end
endmodule // config_fuse_protection_tb
`default_nettype wire
